// ---- clock_gen_pin_control.sv ----
`timescale 1ns/1ps
`include "clock_gen_map.svh"

// Function
// - No good supply at start: everything off
// - After good seen, low pin means sleep
// - Sleep request taken without clock alignment
// - Sleep stops clocks cleanly, outputs low
// - Keep-alive bit keeps oscillator and reference running
// - Wake restarts outputs within restart time
// - Output runs only pin low, bit high
// - Enable bit resets high, pin defaults low
// - Resumed output has no short pulses
// - Disabled output stops at cycle end, low
// - Frequency pin: low 100, mid 200, high 133
// - Spread pin: low -0.25, mid off, high -0.5
// - Address strap latched once at power-up
// - Strap pin then drives reference clock out
// - Strap 0 and 1 select two addresses
module clock_gen_pin_control
	import clock_gen_pkg::*;
#(
	parameter int N_OUT = 4,
	parameter int DIV_CYCLES = `OUT_DIV_CYCLES,
	parameter int SETTLE_CYCLES = `OSC_SETTLE_CYCLES,
	parameter int MAX_RESTART_CYCLES = `RESTART_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic supply_good_input,
	input wire logic [N_OUT-1:0] output_enable_pin_n,
	input wire logic [N_OUT-1:0] oe_bit,
	input wire logic xtal_keep_alive_bit,
	input wire logic [1:0] frequency_select,
	input wire logic [1:0] spread_select,
	input wire logic address_strap_in,
	output logic address_strap_out,
	output logic address_strap_oe,
	output logic [N_OUT-1:0] clk_out,
	output logic osc_enable,
	output logic regport_enable,
	output logic power_down,
	output cfg_out_t cfg
);
	localparam int SW = N_OUT + 6;
	localparam logic [SW-1:0] SYNC_RST = {`SLEEP_PIN_RESET, {N_OUT{`OE_PIN_RESET}},
		`TRI_LOW, `TRI_HIGH, `STRAP_RESET};

	typedef struct packed {
		pwr_state_t ps;
		logic [15:0] cnt;
		logic [7:0] div_cnt;
		logic phase;
		logic [N_OUT-1:0] run;
		logic [N_OUT-1:0] outs;
		logic [N_OUT-1:0] oe_bits;
		logic osc_en;
		logic reg_en;
		logic strap_done;
		logic ref_out;
		logic pd;
		cfg_out_t cfg;
	} ctl_state_t;

	ctl_state_t st_reg;
	ctl_state_t st_next;
	logic [SW-1:0] sync_q;
	logic sleep_n_s;
	logic [N_OUT-1:0] pin_n_s;
	logic [1:0] fs_s;
	logic [1:0] ss_s;
	logic strap_s;
	logic tick;
	logic [N_OUT-1:0] want;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (N_OUT < 1 || N_OUT > 12) begin : g_bad_n_out
		$error("N_OUT out of range");
	end
	if (DIV_CYCLES < 1 || DIV_CYCLES > 255) begin : g_bad_div
		$error("DIV_CYCLES out of range");
	end
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
		$error("SETTLE_CYCLES out of range");
	end
	if (SETTLE_CYCLES + 4 * DIV_CYCLES > MAX_RESTART_CYCLES) begin : g_bad_restart
		$error("restart too slow");
	end

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	function automatic freq_sel_t decode_freq(input logic [1:0] lvl);
		case (lvl)
			`TRI_MID: decode_freq = FREQ_200;
			`TRI_HIGH: decode_freq = FREQ_133;
			default: decode_freq = FREQ_100;
		endcase
	endfunction : decode_freq

	function automatic spread_sel_t decode_spread(input logic [1:0] lvl);
		case (lvl)
			`TRI_LOW: decode_spread = SPREAD_025;
			`TRI_MID: decode_spread = SPREAD_OFF;
			default: decode_spread = SPREAD_050;
		endcase
	endfunction : decode_spread

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	pin_sync #(
		.W(SW),
		.RESET_VAL(SYNC_RST)
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.d({supply_good_input, output_enable_pin_n, frequency_select, spread_select,
			address_strap_in}),
		.q(sync_q)
	);

	assign {sleep_n_s, pin_n_s, fs_s, ss_s, strap_s} = sync_q;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		tick = st_reg.osc_en && (st_reg.div_cnt == 8'(DIV_CYCLES - 1));
		want = ~pin_n_s & st_reg.oe_bits & {N_OUT{st_reg.ps == PS_RUN}};
		st_next.oe_bits = oe_bit;
		// Divider runs only with the oscillator
		if (!st_reg.osc_en || tick) begin
			st_next.div_cnt = 8'h00;
		end else begin
			st_next.div_cnt = st_reg.div_cnt + 8'h01;
		end
		// Output gating on whole cycles only
		if (tick) begin
			st_next.phase = ~st_reg.phase;
			if (!st_reg.phase) begin
				st_next.run = want;
			end
			st_next.outs = st_next.run & {N_OUT{~st_reg.phase}};
		end
		// Power state machine
		case (st_reg.ps)
			PS_WAIT_GOOD: begin
				st_next.osc_en = 1'b0;
				st_next.reg_en = 1'b0;
				if (sleep_n_s) begin
					st_next.strap_done = 1'b1;
					st_next.cfg.bus_address = strap_s ? `ADDR_STRAP1 : `ADDR_STRAP0;
					st_next.osc_en = 1'b1;
					st_next.ps = PS_RUN;
				end
			end
			PS_RUN: begin
				st_next.reg_en = 1'b1;
				if (!sleep_n_s) begin
					st_next.reg_en = 1'b0;
					st_next.ps = PS_STOP;
				end
			end
			PS_STOP: begin
				st_next.reg_en = 1'b0;
				if (st_reg.run == '0 && st_reg.outs == '0) begin
					st_next.osc_en = xtal_keep_alive_bit;
					st_next.ps = PS_SLEEP;
				end
			end
			PS_SLEEP: begin
				st_next.osc_en = xtal_keep_alive_bit;
				if (sleep_n_s) begin
					st_next.osc_en = 1'b1;
					st_next.cnt = 16'h0000;
					st_next.ps = PS_WAKE;
				end
			end
			PS_WAKE: begin
				st_next.cnt = st_reg.cnt + 16'h0001;
				if (!sleep_n_s) begin
					st_next.ps = PS_STOP;
				end else if (st_reg.cnt == 16'(SETTLE_CYCLES - 1)) begin
					st_next.reg_en = 1'b1;
					st_next.ps = PS_RUN;
				end
			end
			default: begin
				st_next.ps = PS_WAIT_GOOD;
			end
		endcase
		if (!st_next.osc_en) begin
			st_next.phase = 1'b0;
		end
		// Tri-level settings applied from reset onward
		st_next.cfg.freq = decode_freq(fs_s);
		st_next.cfg.spread = decode_spread(ss_s);
		st_next.ref_out = st_next.phase & st_next.strap_done & st_next.osc_en;
		st_next.pd = (st_next.ps == PS_SLEEP);
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg.ps <= PS_WAIT_GOOD;
			st_reg.cnt <= 16'h0000;
			st_reg.div_cnt <= 8'h00;
			st_reg.phase <= 1'b0;
			st_reg.run <= '0;
			st_reg.outs <= '0;
			st_reg.oe_bits <= {N_OUT{`OE_BIT_RESET}};
			st_reg.osc_en <= 1'b0;
			st_reg.reg_en <= 1'b0;
			st_reg.strap_done <= 1'b0;
			st_reg.ref_out <= 1'b0;
			st_reg.pd <= 1'h0;
			st_reg.cfg <= {FREQ_100, SPREAD_050, `ADDR_STRAP1};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs straight from flops
	// ----------------------------------------
	assign clk_out = st_reg.outs;
	assign osc_enable = st_reg.osc_en;
	assign regport_enable = st_reg.reg_en;
	assign power_down = st_reg.pd;
	assign address_strap_out = st_reg.ref_out;
	assign address_strap_oe = st_reg.strap_done;
	assign cfg = st_reg.cfg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_wait_off;
		st_reg.ps == PS_WAIT_GOOD |-> clk_out == '0 && !osc_enable && !regport_enable;
	endproperty
	a_wait_off: assert property (p_wait_off) else $error("outputs alive before good");

	property p_sleep_req;
		st_reg.ps == PS_RUN && !sleep_n_s |=> st_reg.ps == PS_STOP && !regport_enable;
	endproperty
	a_sleep_req: assert property (p_sleep_req) else $error("sleep request not taken");

	property p_sleep_quiet;
		power_down && $past(power_down) |-> clk_out == '0 && !regport_enable
			&& osc_enable == $past(xtal_keep_alive_bit);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep state wrong");

	property p_wake_bound;
		st_reg.ps == PS_WAKE |-> st_reg.cnt < 16'(SETTLE_CYCLES) && osc_enable;
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake overran");

	property p_no_glitch;
		!$past(tick) |-> $stable(clk_out);
	endproperty
	a_no_glitch: assert property (p_no_glitch) else $error("output changed off edge");

	property p_stop_low;
		$fell(st_reg.run[0]) |-> !clk_out[0] ##1 !clk_out[0];
	endproperty
	a_stop_low: assert property (p_stop_low) else $error("stop not low");

	property p_pin_gate;
		$rose(st_reg.run[0]) |-> $past(!pin_n_s[0] && st_reg.oe_bits[0]);
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("output started while off");

	property p_addr_hold;
		st_reg.strap_done |=> st_reg.strap_done && $stable(cfg.bus_address);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address changed");

	property p_ref_after;
		address_strap_out |-> address_strap_oe && osc_enable;
	endproperty
	a_ref_after: assert property (p_ref_after) else $error("reference before latch");

	property p_freq_mid;
		fs_s == `TRI_MID |=> cfg.freq == FREQ_200;
	endproperty
	a_freq_mid: assert property (p_freq_mid) else $error("mid frequency wrong");

	property p_spread_mid;
		ss_s == `TRI_MID |=> cfg.spread == SPREAD_OFF;
	endproperty
	a_spread_mid: assert property (p_spread_mid) else $error("mid spread wrong");

	property p_addr_pick;
		$rose(st_reg.strap_done) |->
			cfg.bus_address == ($past(strap_s) ? `ADDR_STRAP1 : `ADDR_STRAP0);
	endproperty
	a_addr_pick: assert property (p_addr_pick) else $error("strap address wrong");

	c_sleep: cover property (st_reg.ps == PS_STOP ##[1:20] power_down);
	c_wake: cover property (st_reg.ps == PS_WAKE ##1 st_reg.ps == PS_RUN);
	c_stop_out: cover property ($fell(st_reg.run[0]) && st_reg.ps == PS_RUN);
	c_keep: cover property (power_down && osc_enable && address_strap_out);
endmodule : clock_gen_pin_control

// ---- clock_gen_map.svh ----
`ifndef CLOCK_GEN_MAP_SVH
`define CLOCK_GEN_MAP_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 25
`define RESTART_TIME_NS 520000
`define RESTART_CYCLES (`RESTART_TIME_NS / `CLK_PERIOD_NS)
`define OSC_SETTLE_CYCLES 1024
`define OUT_DIV_CYCLES 2

// ----------------------------------------
// Tri-level detector codes
// ----------------------------------------
`define TRI_LOW 2'h0
`define TRI_MID 2'h1
`define TRI_HIGH 2'h3

// ----------------------------------------
// Frequency and spread codes
// ----------------------------------------
`define FREQ_100 2'h0
`define FREQ_133 2'h1
`define FREQ_200 2'h2
`define SPREAD_OFF 2'h0
`define SPREAD_025 2'h1
`define SPREAD_050 2'h2

// ----------------------------------------
// Bus address and reset values
// ----------------------------------------
`define ADDR_STRAP0 7'h69
`define ADDR_STRAP1 7'h6A
`define STRAP_RESET 1'h1
`define OE_BIT_RESET 1'h1
`define OE_PIN_RESET 1'h0
`define SLEEP_PIN_RESET 1'h0

// ----------------------------------------
// Power state codes (one-hot)
// ----------------------------------------
`define PS_WAIT_GOOD 5'h01
`define PS_RUN 5'h02
`define PS_STOP 5'h04
`define PS_SLEEP 5'h08
`define PS_WAKE 5'h10

`endif

// ---- clock_gen_pkg.sv ----
package clock_gen_pkg;
`include "clock_gen_map.svh"

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		TRI_LOW = `TRI_LOW,
		TRI_MID = `TRI_MID,
		TRI_HIGH = `TRI_HIGH
	} tri_level_t;

	typedef enum logic [1:0] {
		FREQ_100 = `FREQ_100,
		FREQ_133 = `FREQ_133,
		FREQ_200 = `FREQ_200
	} freq_sel_t;

	typedef enum logic [1:0] {
		SPREAD_OFF = `SPREAD_OFF,
		SPREAD_025 = `SPREAD_025,
		SPREAD_050 = `SPREAD_050
	} spread_sel_t;

	typedef enum logic [4:0] {
		PS_WAIT_GOOD = `PS_WAIT_GOOD,
		PS_RUN = `PS_RUN,
		PS_STOP = `PS_STOP,
		PS_SLEEP = `PS_SLEEP,
		PS_WAKE = `PS_WAKE
	} pwr_state_t;

	// Applied configuration bundle
	typedef struct packed {
		freq_sel_t freq;
		spread_sel_t spread;
		logic [6:0] bus_address;
	} cfg_out_t;

endpackage : clock_gen_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps

module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;

	sync_state_t st_reg;
	sync_state_t st_next;

	if (W < 1) begin : g_bad_w
		$error("pin_sync: width must be at least 1");
	end

	// ----------------------------------------
	// Two-flop chain, first stage read only by second
	// ----------------------------------------
	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= {RESET_VAL, RESET_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule : pin_sync

// ---- sys_ctrl_model.sv ----
`timescale 1ns/1ps

module sys_ctrl_model
	import clock_gen_pkg::*;
(
	input wire logic sg_drv,
	input wire logic sg_lvl,
	input wire logic oe_drv,
	input wire logic [3:0] oe_lvl,
	input wire logic fs_drv,
	input wire logic [1:0] fs_lvl,
	input wire logic ss_drv,
	input wire logic [1:0] ss_lvl,
	input wire logic sa_drv,
	input wire logic sa_lvl,
	input wire logic sa_dev_out,
	input wire logic sa_dev_oe,
	output logic supply_pin,
	output logic [3:0] oe_pin_n,
	output logic [1:0] fs_pin,
	output logic [1:0] ss_pin,
	output logic sa_pin
);
	// Pin levels, board pulls when released
	always_comb begin
		supply_pin = sg_drv ? sg_lvl : 1'h1;
		oe_pin_n = oe_drv ? oe_lvl : 4'h0;
		fs_pin = fs_drv ? fs_lvl : TRI_LOW;
		ss_pin = ss_drv ? ss_lvl : TRI_HIGH;
		sa_pin = sa_dev_oe ? sa_dev_out : (sa_drv ? sa_lvl : 1'h1);
	end
endmodule : sys_ctrl_model

// ---- tb.sv ----
`timescale 1ns/1ps

module tb
	import clock_gen_pkg::*;
;
	// --------
	// Signals
	// --------
	logic clk, rstn, sg_drv, sg_lvl, oe_drv, fs_drv, ss_drv, sa_drv, sa_lvl, keep;
	logic [3:0] oe_lvl, oe_bits, ck, oe_pin_n;
	logic [1:0] fs_lvl, ss_lvl, fs_pin, ss_pin;
	logic supply_pin, sa_pin, sa_out, sa_oe, osc_en, rp_en, pd;
	cfg_out_t cfg;
	int mismatches, n_checks, cycles;

	sys_ctrl_model ctrl (.sg_drv(sg_drv), .sg_lvl(sg_lvl), .oe_drv(oe_drv), .oe_lvl(oe_lvl),
		.fs_drv(fs_drv), .fs_lvl(fs_lvl), .ss_drv(ss_drv), .ss_lvl(ss_lvl), .sa_drv(sa_drv),
		.sa_lvl(sa_lvl), .sa_dev_out(sa_out), .sa_dev_oe(sa_oe), .supply_pin(supply_pin),
		.oe_pin_n(oe_pin_n), .fs_pin(fs_pin), .ss_pin(ss_pin), .sa_pin(sa_pin));

	clock_gen_pin_control #(.N_OUT(4), .SETTLE_CYCLES(8)) uut (.clk(clk), .rstn(rstn),
		.supply_good_input(supply_pin), .output_enable_pin_n(oe_pin_n), .oe_bit(oe_bits),
		.xtal_keep_alive_bit(keep), .frequency_select(fs_pin), .spread_select(ss_pin),
		.address_strap_in(sa_pin), .address_strap_out(sa_out), .address_strap_oe(sa_oe),
		.clk_out(ck), .osc_enable(osc_en), .regport_enable(rp_en), .power_down(pd), .cfg(cfg));

	// Clock and hang guard
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 25000) begin
			mismatches++;
			close_out();
		end
	end

	// --------
	// Helpers
	// --------
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask : chk

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out

	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task do_reset;
		rstn = 1'h0;
		cyc(5);
		rstn = 1'h1;
	endtask : do_reset

	// Notes whether each output rises and checks every whole high pulse
	task watch(input logic [3:0] run, input logic cnt, input string msg);
		int rises [4];
		int len [4];
		logic [3:0] prev;
		rises = '{default: 0};
		len = '{default: -99};
		prev = ck;
		repeat (16) begin
			@(negedge clk);
			for (int i = 0; i < 4; i++) begin
				if (ck[i] && !prev[i]) rises[i] = 0;
				if (ck[i] && !prev[i]) len[i] = 0;
				if (ck[i]) len[i]++;
				if (!ck[i] && prev[i] && len[i] > 0) chk(len[i], 2, msg);
				if (ck[i] && !prev[i]) rises[i] = 1;
			end
			prev = ck;
		end
		if (cnt) chk(ck & ~run, 4'h0, msg);
		if (cnt) for (int i = 0; i < 4; i++) chk(rises[i], run[i], msg);
	endtask : watch

	task ref_toggles(input int exp);
		int t;
		logic p;
		t = 0;
		p = sa_out;
		repeat (16) begin
			@(negedge clk);
			t += (sa_out !== p);
			p = sa_out;
		end
		chk(t, exp, "reference toggles");
	endtask : ref_toggles

	// --------
	// Scenarios
	// --------
	task t_off;
		cyc(20);
		chk({osc_en, rp_en, sa_oe, ck}, 7'h00, "off before supply good");
	endtask : t_off

	task t_up(input logic drv, input logic lvl, input logic [6:0] addr);
		sa_drv = drv;
		sa_lvl = lvl;
		cyc(2);
		sg_lvl = 1'h1;
		cyc(5);
		chk({osc_en, sa_oe, pd}, 3'h6, "power up");
		chk(cfg.bus_address, addr, "strap address");
		sa_drv = 1'h0;
		cyc(1);
		chk(rp_en, 1'h1, "regport on");
		ref_toggles(8);
		chk(cfg.bus_address, addr, "address latched once");
	endtask : t_up

	task t_outs;
		watch(4'hF, 1'h1, "default run");
		oe_drv = 1'h1;
		oe_lvl = 4'h2;
		chk(rp_en, 1'h1, "port open for bit writes");
		oe_bits = 4'hB;
		watch(4'h0, 1'h0, "clean stop");
		watch(4'h9, 1'h1, "gated outputs");
		oe_lvl = 4'h0;
		oe_bits = 4'hF;
		watch(4'h0, 1'h0, "clean resume");
		watch(4'hF, 1'h1, "resumed outputs");
	endtask : t_outs

	task t_tri;
		logic [1:0] lv [3];
		logic [1:0] fx [3];
		logic [1:0] sx [3];
		lv = '{TRI_LOW, TRI_MID, TRI_HIGH};
		fx = '{FREQ_100, FREQ_200, FREQ_133};
		sx = '{SPREAD_025, SPREAD_OFF, SPREAD_050};
		{fs_drv, ss_drv} = 2'h3;
		for (int i = 0; i < 3; i++) begin
			fs_lvl = lv[i];
			ss_lvl = lv[i];
			cyc(4);
			chk({cfg.freq, cfg.spread}, {fx[i], sx[i]}, "tri-level decode");
		end
		{fs_drv, ss_drv} = 2'h0;
		cyc(4);
		chk({cfg.freq, cfg.spread}, {FREQ_100, SPREAD_050}, "undriven defaults");
	endtask : t_tri

	task t_sleep(input logic keep_on);
		int n;
		keep = keep_on;
		sg_lvl = 1'h0;
		cyc(14);
		chk({pd, rp_en, osc_en}, {2'h2, keep_on}, "sleep state");
		watch(4'h0, 1'h1, "outputs low in sleep");
		ref_toggles(keep_on ? 8 : 0);
		sg_lvl = 1'h1;
		n = 0;
		while (ck === 4'h0 && n < 20800) begin
			@(negedge clk);
			n++;
		end
		chk(n < 20800, 1'h1, "restart time");
		cyc(10);
		chk({pd, rp_en}, 2'h1, "awake");
		watch(4'hF, 1'h1, "outputs after wake");
	endtask : t_sleep

	// --------
	// Main
	// --------
	initial begin
		{rstn, sg_drv, sa_drv, oe_bits} = 7'h3F;
		{sg_lvl, oe_drv, fs_drv, ss_drv, sa_lvl, keep} = 6'h00;
		{oe_lvl, fs_lvl, ss_lvl} = 8'h00;
		do_reset();
		t_off();
		t_up(1'h1, 1'h0, 7'h69);
		t_outs();
		t_tri();
		t_sleep(1'h0);
		t_sleep(1'h1);
		sg_lvl = 1'h0;
		do_reset();
		t_up(1'h0, 1'h0, 7'h6A);
		close_out();
	end
endmodule : tb
